// ==== common/epi_pkg.sv ====
package epi_pkg;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_SENSE = 8'h69;
	localparam logic [7:0] OFS_MASK2 = 8'h6D;
	localparam logic [7:0] OFS_VECTOR = 8'h55;
	localparam logic [7:0] OFS_MASK3 = 8'h73;
	localparam logic [7:0] OFS_MASK1 = 8'h6C;
	localparam logic [7:0] OFS_MASK0 = 8'h6B;
	localparam logic [7:0] OFS_GRP_EN = 8'h68;
	localparam logic [7:0] OFS_EXT_EN = 8'h3D;
	localparam logic [7:0] OFS_EXT_FLAG = 8'h3C;
	localparam logic [7:0] OFS_PC_FLAG = 8'h3B;
	localparam logic [7:0] OFS_PROTECT = 8'h56;

	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int VEC_SEL_BIT = 1;
	localparam int SENSE_B_LSB = 2;
	localparam int SENSE_A_LSB = 0;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] PROTECT_SIG = 8'hD8;
	localparam logic [2:0] PROTECT_WIN = 3'h4;
	localparam int NUM_GROUPS = 4;
	localparam int NUM_PC_PINS = 28;

	typedef enum logic [1:0] {
		SENSE_LOW = 2'b00,
		SENSE_ANY = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} epi_sense_t;

	// register bus carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} epi_bus_t;

	// core-side acknowledge carrier
	typedef struct packed {
		logic [1:0] ext_ack;
		logic [3:0] grp_ack;
	} epi_ack_t;

endpackage

// ==== verilog/epi_unit.sv ====
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module epi_unit #(
	parameter int NPC = epi_pkg::NUM_PC_PINS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire epi_pkg::epi_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [1:0] ext_pin,
	input wire logic [NPC-1:0] pc_pin,
	input wire logic global_ie,
	input wire logic exec_in_boot,
	input wire logic app_lock_bit,
	input wire logic boot_lock_bit,
	input wire epi_pkg::epi_ack_t ack,
	output logic [1:0] ext_irq,
	output logic [3:0] grp_irq,
	output logic vector_place_select,
	output logic pc_wake
);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [3:0] sense_r;
	logic [7:0] mask0_r, mask1_r, mask2_r;
	logic [3:0] mask3_r;
	logic [3:0] grp_en_r;
	logic [1:0] ext_en_r;
	logic [1:0] ext_flag_r;
	logic [3:0] pc_flag_r;
	logic vsel_r;
	logic [2:0] prot_cnt_r;
	logic [1:0] ext_s1_r, ext_s2_r, ext_s3_r;
	logic [NPC-1:0] pc_s1_r, pc_s2_r, pc_s3_r;

	function automatic logic wr_at(input epi_pkg::epi_bus_t b,
		input logic [7:0] ofs);
		wr_at = b.wr && (b.addr == ofs);
	endfunction

	function automatic logic edge_hit(input logic [1:0] sense,
		input logic now, input logic prev);
		case (epi_pkg::epi_sense_t'(sense))
			epi_pkg::SENSE_ANY: edge_hit = now ^ prev;
			epi_pkg::SENSE_FALL: edge_hit = prev & ~now;
			epi_pkg::SENSE_RISE: edge_hit = now & ~prev;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// decode and detection
	// ---------------------------------------------------------------
	wire w_sense = wr_at(bus, epi_pkg::OFS_SENSE);
	wire w_mask0 = wr_at(bus, epi_pkg::OFS_MASK0);
	wire w_mask1 = wr_at(bus, epi_pkg::OFS_MASK1);
	wire w_mask2 = wr_at(bus, epi_pkg::OFS_MASK2);
	wire w_mask3 = wr_at(bus, epi_pkg::OFS_MASK3);
	wire w_grp = wr_at(bus, epi_pkg::OFS_GRP_EN);
	wire w_ext_en = wr_at(bus, epi_pkg::OFS_EXT_EN);
	wire w_ext_fl = wr_at(bus, epi_pkg::OFS_EXT_FLAG);
	wire w_pc_fl = wr_at(bus, epi_pkg::OFS_PC_FLAG);
	wire w_vec = wr_at(bus, epi_pkg::OFS_VECTOR);
	wire w_prot = wr_at(bus, epi_pkg::OFS_PROTECT);
	// the key opens a short window; a late write is silently dropped
	wire prot_open = (prot_cnt_r != 3'h0);
	wire vec_take = w_vec && prot_open;

	wire [1:0] sense_a = sense_r[epi_pkg::SENSE_A_LSB +: 2];
	wire [1:0] sense_b = sense_r[epi_pkg::SENSE_B_LSB +: 2];
	// pin level seen regardless of its port direction
	wire [1:0] ext_hit = {
		edge_hit(sense_b, ext_s2_r[1], ext_s3_r[1]),
		edge_hit(sense_a, ext_s2_r[0], ext_s3_r[0])
	};
	wire [1:0] low_mode = {sense_b == 2'b00, sense_a == 2'b00};
	// low level requests directly, caller keeps it low long enough
	wire [1:0] low_req = low_mode & ~ext_s2_r;

	wire [31:0] pc_mask_all = {mask3_r, mask2_r, mask1_r, mask0_r};
	wire [NPC-1:0] pc_chg = (pc_s2_r ^ pc_s3_r) & pc_mask_all[NPC-1:0];
	wire [31:0] pc_chg_w = 32'(pc_chg);
	wire [3:0] grp_hit = {
		|pc_chg_w[27:24], |pc_chg_w[23:16],
		|pc_chg_w[15:8], |pc_chg_w[7:0]
	};
	// wake hint follows the synchronised change; needs the clock running
	assign pc_wake = |pc_chg;

	wire blocked = (vsel_r && app_lock_bit && !exec_in_boot)
		|| (!vsel_r && boot_lock_bit && exec_in_boot);
	wire ie = global_ie && !blocked;

	wire [1:0] ext_flag_vis = ext_flag_r & ~low_mode;
	wire [1:0] ext_clr = (w_ext_fl ? bus.wdata[1:0] : 2'b00)
		| ack.ext_ack;
	wire [3:0] pc_clr = (w_pc_fl ? bus.wdata[3:0] : 4'h0)
		| ack.grp_ack;
	// set beats clear in the same cycle
	wire [1:0] ext_flag_nxt = (ext_flag_r & ~ext_clr) | ext_hit;
	wire [3:0] pc_flag_nxt = (pc_flag_r & ~pc_clr) | grp_hit;

	assign ext_irq = (ext_flag_vis | low_req) & ext_en_r & {2{ie}};
	assign grp_irq = pc_flag_r & grp_en_r & {4{ie}};
	assign vector_place_select = vsel_r;

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		unique case (bus.addr)
			epi_pkg::OFS_SENSE: rd_mux = {4'h0, sense_r};
			epi_pkg::OFS_MASK0: rd_mux = mask0_r;
			epi_pkg::OFS_MASK1: rd_mux = mask1_r;
			epi_pkg::OFS_MASK2: rd_mux = mask2_r;
			epi_pkg::OFS_MASK3: rd_mux = {4'h0, mask3_r};
			epi_pkg::OFS_GRP_EN: rd_mux = {4'h0, grp_en_r};
			epi_pkg::OFS_EXT_EN: rd_mux = {6'h00, ext_en_r};
			epi_pkg::OFS_EXT_FLAG: rd_mux = {6'h00, ext_flag_vis};
			epi_pkg::OFS_PC_FLAG: rd_mux = {4'h0, pc_flag_r};
			epi_pkg::OFS_VECTOR: rd_mux = {6'h00, vsel_r, 1'b0};
			default: rd_mux = 8'h00;
		endcase
	end

	// ---------------------------------------------------------------
	// sequential
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_s1_r <= 2'h0;
			ext_s2_r <= 2'h0;
			ext_s3_r <= 2'h0;
			pc_s1_r <= '0;
			pc_s2_r <= '0;
			pc_s3_r <= '0;
		end else begin
			ext_s1_r <= ext_pin;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			pc_s1_r <= pc_pin;
			pc_s2_r <= pc_s1_r;
			pc_s3_r <= pc_s2_r;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sense_r <= 4'h0;
			mask0_r <= epi_pkg::RESET_VAL;
			mask1_r <= epi_pkg::RESET_VAL;
			mask2_r <= epi_pkg::RESET_VAL;
			mask3_r <= 4'h0;
			grp_en_r <= 4'h0;
			ext_en_r <= 2'h0;
		end else begin
			if (w_sense) sense_r <= bus.wdata[3:0];
			if (w_mask0) mask0_r <= bus.wdata;
			if (w_mask1) mask1_r <= bus.wdata;
			if (w_mask2) mask2_r <= bus.wdata;
			if (w_mask3) mask3_r <= bus.wdata[3:0];
			if (w_grp) grp_en_r <= bus.wdata[3:0];
			if (w_ext_en) ext_en_r <= bus.wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_flag_r <= 2'h0;
			pc_flag_r <= 4'h0;
			vsel_r <= 1'b0;
			prot_cnt_r <= 3'h0;
			rdata <= 8'h00;
		end else begin
			ext_flag_r <= ext_flag_nxt;
			pc_flag_r <= pc_flag_nxt;
			if (vec_take) vsel_r <= bus.wdata[epi_pkg::VEC_SEL_BIT];
			if (w_prot && bus.wdata == epi_pkg::PROTECT_SIG)
				prot_cnt_r <= epi_pkg::PROTECT_WIN;
			else if (prot_open)
				prot_cnt_r <= prot_cnt_r - 3'h1;
			rdata <= bus.rd ? rd_mux : 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_vec_locked: assert property (@(posedge clk) disable iff (!nrst)
		(bus.wr && bus.addr == epi_pkg::OFS_VECTOR && !prot_open)
		|=> $stable(vsel_r))
		else $error("vector select changed unlocked");
	chk_vec_take: assert property (@(posedge clk) disable iff (!nrst)
		vec_take
		|=> (vsel_r == $past(bus.wdata[epi_pkg::VEC_SEL_BIT])))
		else $error("vector select write lost");
	chk_prot_arm: assert property (@(posedge clk) disable iff (!nrst)
		(w_prot && bus.wdata == epi_pkg::PROTECT_SIG)
		|=> (prot_cnt_r == epi_pkg::PROTECT_WIN))
		else $error("signature did not open window");
	chk_prot_shut: assert property (@(posedge clk) disable iff (!nrst)
		(!prot_open && !w_prot)
		|=> !prot_open)
		else $error("window opened without signature");
	chk_vec_out: assert property (@(posedge clk) disable iff (!nrst)
		$changed(vector_place_select)
		|-> $past(vec_take))
		else $error("vector placement moved by itself");
	chk_boot_block: assert property (@(posedge clk) disable iff (!nrst)
		(vsel_r && app_lock_bit && !exec_in_boot)
		|-> (ext_irq == 2'b00))
		else $error("interrupt while blocked");
	chk_boot_grp: assert property (@(posedge clk) disable iff (!nrst)
		(vsel_r && app_lock_bit && !exec_in_boot)
		|-> (grp_irq == 4'h0))
		else $error("group interrupt while blocked");
	chk_app_block: assert property (@(posedge clk) disable iff (!nrst)
		(!vsel_r && boot_lock_bit && exec_in_boot)
		|-> (ext_irq == 2'b00 && grp_irq == 4'h0))
		else $error("interrupt while boot code blocked");

	// ---------------------------------------------------------------
	// register read checks
	// ---------------------------------------------------------------
	chk_resv_zero: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_PC_FLAG)
		|=> rdata[7:4] == 4'h0)
		else $error("reserved bits not zero");
	chk_resv_sense: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_SENSE)
		|=> rdata[7:4] == 4'h0)
		else $error("reserved sense bits not zero");
	chk_resv_mask3: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_MASK3)
		|=> rdata[7:4] == 4'h0)
		else $error("reserved mask bits not zero");
	chk_resv_grp: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_GRP_EN)
		|=> rdata[7:4] == 4'h0)
		else $error("reserved group enable bits not zero");
	chk_resv_ext: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_EXT_EN)
		|=> rdata[7:2] == 6'h00)
		else $error("reserved enable bits not zero");
	chk_resv_eflag: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_EXT_FLAG)
		|=> rdata[7:2] == 6'h00)
		else $error("reserved flag bits not zero");
	chk_resv_vector: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_VECTOR)
		|=> (rdata[7:2] == 6'h00 && !rdata[0]))
		else $error("reserved vector bits not zero");
	chk_low_read: assert property (@(posedge clk) disable iff (!nrst)
		(bus.rd && bus.addr == epi_pkg::OFS_EXT_FLAG && low_mode[0])
		|=> !rdata[0])
		else $error("low level flag read as set");

	// ---------------------------------------------------------------
	// external pin checks
	// ---------------------------------------------------------------
	chk_pin_two_flop: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst, 2)
		|-> (ext_s2_r == $past(ext_pin, 2)))
		else $error("pin not delayed by two flops");
	chk_pin_sync: assert property (@(posedge clk) disable iff (!nrst)
		(sense_b == 2'b10 && $stable(sense_r) && ext_pin[1] ##1
		!ext_pin[1] ##1 1'b1 ##1 1'b1 ##1 1'b1)
		|-> ext_flag_r[1] || $past(ext_clr[1]))
		else $error("falling edge on pin b missed");
	chk_ext_rise: assert property (@(posedge clk) disable iff (!nrst)
		(sense_a == 2'b11 && $rose(ext_s2_r[0]))
		|=> ext_flag_r[0])
		else $error("rising edge missed on pin a");
	chk_ext_fall: assert property (@(posedge clk) disable iff (!nrst)
		(sense_b == 2'b10 && $fell(ext_s2_r[1]))
		|=> ext_flag_r[1])
		else $error("falling edge missed on pin b");
	chk_ext_any: assert property (@(posedge clk) disable iff (!nrst)
		(sense_a == 2'b01 && $changed(ext_s2_r[0]))
		|=> ext_flag_r[0])
		else $error("toggle missed on pin a");
	chk_low_noflag: assert property (@(posedge clk) disable iff (!nrst)
		(sense_a == 2'b00 && !ext_flag_r[0])
		|=> !ext_flag_r[0])
		else $error("flag set in low level mode");
	chk_low_req: assert property (@(posedge clk) disable iff (!nrst)
		(sense_a == 2'b00 && !ext_s2_r[0] && ext_en_r[0] && ie)
		|-> ext_irq[0])
		else $error("low level request missing");
	chk_ext_gate: assert property (@(posedge clk) disable iff (!nrst)
		ext_irq[0]
		|-> (ext_en_r[0] && global_ie))
		else $error("external request without enable");
	chk_ext_gate_b: assert property (@(posedge clk) disable iff (!nrst)
		ext_irq[1]
		|-> (ext_en_r[1] && global_ie))
		else $error("external request b without enable");
	chk_eflag_set: assert property (@(posedge clk) disable iff (!nrst)
		ext_hit[0]
		|=> ext_flag_r[0])
		else $error("pin activity did not set flag");
	chk_eflag_w1c: assert property (@(posedge clk) disable iff (!nrst)
		(w_ext_fl && bus.wdata[0] && !ext_hit[0])
		|=> !ext_flag_r[0])
		else $error("external flag not cleared by write");
	chk_eflag_ack: assert property (@(posedge clk) disable iff (!nrst)
		(ack.ext_ack[1] && !ext_hit[1])
		|=> !ext_flag_r[1])
		else $error("external flag not cleared on entry");

	// ---------------------------------------------------------------
	// pin change checks
	// ---------------------------------------------------------------
	chk_flag_w1c: assert property (@(posedge clk) disable iff (!nrst)
		(w_pc_fl && bus.wdata[2] && !grp_hit[2])
		|=> !pc_flag_r[2])
		else $error("pin change flag not cleared");
	chk_pc_ack: assert property (@(posedge clk) disable iff (!nrst)
		(ack.grp_ack[3] && !grp_hit[3])
		|=> !pc_flag_r[3])
		else $error("pin change flag not cleared on entry");
	chk_mask_off: assert property (@(posedge clk) disable iff (!nrst)
		(mask0_r == 8'h00 && !pc_flag_r[0])
		|=> !pc_flag_r[0])
		else $error("masked pin set group flag");
	chk_mask_gate: assert property (@(posedge clk) disable iff (!nrst)
		grp_hit[1]
		|-> (|pc_mask_all[15:8]))
		else $error("group hit with all pins masked");
	chk_grp_gate: assert property (@(posedge clk) disable iff (!nrst)
		grp_irq[3]
		|-> (grp_en_r[3] && pc_flag_r[3] && global_ie))
		else $error("group request without enable");
	chk_grp_gate0: assert property (@(posedge clk) disable iff (!nrst)
		grp_irq[0]
		|-> (grp_en_r[0] && pc_flag_r[0] && global_ie))
		else $error("group 0 request without enable");
	chk_grp3_set: assert property (@(posedge clk) disable iff (!nrst)
		grp_hit[3]
		|=> pc_flag_r[3])
		else $error("group 3 change did not set flag");
	chk_grp2_set: assert property (@(posedge clk) disable iff (!nrst)
		grp_hit[2]
		|=> pc_flag_r[2])
		else $error("group 2 change did not set flag");
	chk_wake_flag: assert property (@(posedge clk) disable iff (!nrst)
		pc_wake
		|=> (pc_flag_r != 4'h0))
		else $error("wake hint without group flag");

endmodule

// ==== dv/epi_core_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// core stand-in: takes pending requests after LAT+1 cycles
// ---------------------------------------------------------------
module epi_core_model #(
	parameter int LAT = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] ext_irq,
	input wire logic [3:0] grp_irq,
	output epi_pkg::epi_ack_t ack
);
	logic [3:0] wait_r;
	// acks all pending at once; a real core takes one vector at a time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack <= '0;
			wait_r <= 4'h0;
		end else begin
			ack <= '0;
			if (ack != '0 || !(|{ext_irq, grp_irq})) begin
				wait_r <= 4'h0;
			end else if (wait_r == 4'(LAT)) begin
				ack <= '{ext_ack: ext_irq, grp_ack: grp_irq};
				wait_r <= 4'h0;
			end else begin
				wait_r <= wait_r + 4'h1;
			end
		end
	end
endmodule

// ==== dv/external_pin_interrupt_unit_tb_top.sv ====
`timescale 1ns/1ps
module external_pin_interrupt_unit_tb_top;
	logic clk = 0, nrst = 0, rd_d = 0, vsel, pc_wake;
	logic global_ie = 0, exec_in_boot = 0, app_lock = 0, boot_lock = 0;
	epi_pkg::epi_bus_t bus = '0;
	epi_pkg::epi_ack_t ack;
	logic [7:0] rdata, m8;
	logic [1:0] ext_pin = 2'h3, ext_irq;
	logic [3:0] grp_irq;
	logic [27:0] pc_pin = '0;
	logic [31:0] seed = 32'h0001221C;
	logic [7:0] expq[$];
	int err_total = 0, cmp_count = 0, p;
	int wake_cnt = 0, w0;
	logic [7:0] ofs[10] = '{8'h69, 8'h6D, 8'h55, 8'h73, 8'h6C, 8'h6B,
		8'h68, 8'h3D, 8'h3C, 8'h00};
	logic [7:0] msk[10] = '{8'h0F, 8'hFF, 8'h00, 8'h0F, 8'hFF, 8'hFF,
		8'h0F, 8'h03, 8'h00, 8'h00};
	logic [7:0] mo[4] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};

	initial forever #5 clk = ~clk;

	epi_unit epi_unit_inst (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
		.ext_pin(ext_pin), .pc_pin(pc_pin), .global_ie(global_ie),
		.exec_in_boot(exec_in_boot), .app_lock_bit(app_lock),
		.boot_lock_bit(boot_lock), .ack(ack), .ext_irq(ext_irq),
		.grp_irq(grp_irq), .vector_place_select(vsel), .pc_wake(pc_wake));
	epi_core_model #(.LAT(3)) epi_core_model_inst (.clk(clk), .nrst(nrst),
		.ext_irq(ext_irq), .grp_irq(grp_irq), .ack(ack));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one access; strobes drop at the edge that takes them
	task automatic acc(input logic [7:0] a, d, input logic w, r);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: w, rd: r};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic wr(input logic [7:0] a, d);
		acc(a, d, 1'b1, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, e);
		expq.push_back(e);
		acc(a, 8'h00, 1'b0, 1'b1);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk) rd_d <= bus.rd;
	always @(posedge clk) wake_cnt <= wake_cnt + ((pc_wake === 1'b1) ? 1 : 0);
	always @(negedge clk) begin
		if (rd_d === 1'b1 && expq.size() > 0) begin
			check(rdata, expq.pop_front());
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		foreach (ofs[i]) rd(ofs[i], 8'h00);
		foreach (ofs[i]) begin
			wr(ofs[i], 8'hFF);
			rd(ofs[i], msk[i]);
			wr(ofs[i], 8'h00);
		end
		$display("register test done");
		wr(8'h56, epi_pkg::PROTECT_SIG);
		wr(8'h55, 8'h02);
		rd(8'h55, 8'h02);
		wt(1);
		check({7'h0, vsel}, 8'h01);
		wr(8'h3D, 8'h01);
		@(posedge clk);
		{global_ie, app_lock, boot_lock} <= 3'b111;
		ext_pin <= 2'h2;
		wt(4);
		check({6'h0, ext_irq}, 8'h00);
		@(posedge clk);
		exec_in_boot <= 1'b1;
		wt(4);
		check({6'h0, ext_irq}, 8'h01);
		@(posedge clk);
		global_ie <= 1'b0;
		wt(1);
		check({6'h0, ext_irq}, 8'h00);
		rd(8'h3C, 8'h00);
		ext_pin <= 2'h3;
		wr(8'h3D, 8'h00);
		$display("level test done");
		for (int m = 1; m < 4; m++) begin
			wr(8'h69, {4'h0, 2'(m), 2'(m)});
			wr(8'h3C, 8'h03);
			ext_pin <= 2'h0;
			wt(5);
			rd(8'h3C, (m != 3) ? 8'h03 : 8'h00);
			wr(8'h3C, 8'h03);
			ext_pin <= 2'h3;
			wt(5);
			rd(8'h3C, (m != 2) ? 8'h03 : 8'h00);
		end
		// serviced by the core model: entry clears the flags
		wr(8'h3D, 8'h03);
		global_ie <= 1'b1;
		wt(8);
		rd(8'h3C, 8'h00);
		global_ie <= 1'b0;
		wr(8'h3D, 8'h00);
		$display("edge test done");
		wr(8'h68, 8'h0F);
		for (int k = 0; k < 12; k++) begin
			seed = xs(seed);
			p = seed % 28;
			m8 = seed[15:8];
			wr(mo[p / 8], m8);
			wr(8'h3B, 8'h0F);
			w0 = wake_cnt;
			pc_pin <= pc_pin ^ (28'h1 << p);
			wt(5);
			rd(8'h3B, {7'h0, m8[p % 8]} << (p / 8));
			check(8'(wake_cnt - w0), {7'h0, m8[p % 8]});
			check({4'h0, grp_irq}, 8'h00);
		end
		wr(8'h3B, 8'h0F);
		rd(8'h3B, 8'h00);
		wr(8'h6B, 8'h01);
		pc_pin <= pc_pin ^ 28'h1;
		global_ie <= 1'b1;
		wt(10);
		rd(8'h3B, 8'h00);
		$display("pin change test done");
		wr(8'h56, epi_pkg::PROTECT_SIG);
		wr(8'h55, 8'h00);
		wr(8'h69, 8'h00);
		wr(8'h3D, 8'h01);
		ext_pin <= 2'h2;
		wt(2);
		check({7'h0, vsel}, 8'h00);
		wt(2);
		check({6'h0, ext_irq}, 8'h00);
		@(posedge clk);
		exec_in_boot <= 1'b0;
		wt(1);
		check({6'h0, ext_irq}, 8'h01);
		$display("lock test done");
		wt(3);
		check(8'(expq.size()), 8'h00);
		complete_run();
	end
endmodule
